// File: src/aiac_top.sv
// Acquisition sequencing, sample buffer control and APB registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module aiac_top #(
  parameter int MEM_AW = aiac_pkg::MEM_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  output logic irq_ff,
  input wire logic ext_start,
  input wire logic ext_stop,
  input wire logic ext_clk,
  input wire logic evt_start,
  input wire logic evt_stop,
  output logic conv_req_ff,
  output logic [4:0] ch_sel_ff,
  output logic diff_mode_ff,
  input wire logic conv_valid,
  input wire logic [aiac_pkg::DW-1:0] conv_data,
  output logic [1:0] stat_out_ff,
  output logic sync_tick_ff
);
  import aiac_pkg::*;
  localparam logic [MEM_AW:0] CAP = (MEM_AW+1)'(1) << MEM_AW;

  logic [CTRL_W-1:0] ctrl_ff;
  logic [3:0] irq_st_ff, irq_mask_ff;
  logic [15:0] div_ff, div_cnt_ff, cmpv_ff;
  logic [4:0] chn_ff;
  logic [31:0] save_ff, saved_ff;
  logic [2:0] ext_prev_ff;
  aiac_state_type state_ff, nxt_state;
  logic [MEM_AW-1:0] wp_ff, rp_ff;
  logic [MEM_AW:0] cnt_ff;
  logic [DW-1:0] mem_rdata;

  // ==========================================================
  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & ~pready_ff;
  wire done_x = psel & penable & pready_ff;
  wire wr_x = done_x & pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_stat = paddr == OFS_STAT;
  wire hit_irq = paddr == OFS_IRQ;
  wire hit_mask = paddr == OFS_MASK;
  wire hit_div = paddr == OFS_DIV;
  wire hit_chn = paddr == OFS_CHN;
  wire hit_cmpv = paddr == OFS_CMPV;
  wire hit_save = paddr == OFS_SAVE;
  wire hit_data = paddr == OFS_DATA;
  wire mapped = hit_ctrl | hit_cmd | hit_stat | hit_irq | hit_mask | hit_div | hit_chn
    | hit_cmpv | hit_save | hit_data;
  wire cmd_wr = wr_x & hit_cmd;

  // ==========================================================
  // Trigger edges and source selection
  // Polarity bit low picks the rising edge, high the falling one
  wire [2:0] ext_now = {ext_clk, ext_stop, ext_start};
  wire [2:0] pol = {ctrl_ff[B_CPOL], ctrl_ff[B_PPOL], ctrl_ff[B_SPOL]};
  wire [2:0] ext_edge = (ext_now ^ ext_prev_ff) & (ext_now ^ {3{1'b0}} ^ pol);
  wire [3:0] st_en = ctrl_ff[B_STEN +: 4];
  wire [4:0] sp_en = ctrl_ff[B_SPEN +: 5];
  wire running = state_ff == ST_RUN;
  wire armed = state_ff == ST_IDLE;
  wire cmp_hit = conv_valid & (conv_data >= cmpv_ff);
  wire save_done = running & (saved_ff >= save_ff);
  wire [3:0] st_src = {evt_start, ext_edge[0], cmp_hit, cmd_wr & pwdata[C_START]};
  wire [4:0] sp_src = {cmd_wr & pwdata[C_STOP], evt_stop, ext_edge[1], cmp_hit,
    save_done};
  wire start_hit = armed & |(st_src & st_en);
  wire stop_hit = running & |(sp_src & sp_en);
  wire rearm = cmd_wr & pwdata[C_REARM];

  // ==========================================================
  // Run state: one start per arming, first stop ends the run
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start_hit) nxt_state = ST_RUN;
      ST_RUN: if (stop_hit) nxt_state = ST_DONE;
      ST_DONE: if (rearm) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Sampling clock: internal divider or selected external edge
  // Converter keeps sampling while armed for a compare start
  wire sampling = running | (armed & st_en[S_CMP]);
  wire int_tick = div_cnt_ff >= div_ff;
  wire tick = sampling & (ctrl_ff[B_EXTCLK] ? ext_edge[2] : int_tick);
  wire [4:0] ch_last = ctrl_ff[B_DIFF] ? ((chn_ff > 5'(NCH_DIFF-1)) ? 5'(NCH_DIFF-1)
    : chn_ff) : chn_ff;
  wire [4:0] nxt_ch = (ch_sel_ff >= ch_last) ? 5'h00 : ch_sel_ff + 5'h01;
  wire [15:0] nxt_div_cnt = (int_tick | ~sampling) ? 16'h0000 : div_cnt_ff + 16'h0001;

  // ==========================================================
  // Buffer pointers: FIFO holds on full, ring drops the oldest
  wire full = cnt_ff == CAP;
  wire empty = cnt_ff == '0;
  wire store = running & conv_valid;
  wire ring = ctrl_ff[B_RING];
  wire overrun = store & full & ~ring;
  wire do_wr = store & (~full | ring);
  wire drop = store & full & ring;
  wire pop = done_x & ~pwrite & hit_data & ~empty & ~drop;
  wire adv_rp = pop | drop;
  wire [MEM_AW:0] nxt_cnt = rearm ? '0 : cnt_ff + (MEM_AW+1)'(do_wr & ~drop)
    - (MEM_AW+1)'(pop);

  aiac_sample_mem #(
    .AW(MEM_AW),
    .DW(DW)
  ) u_mem (
    .pclk(pclk),
    .we(do_wr),
    .waddr(wp_ff),
    .wdata(conv_data),
    .raddr(rp_ff),
    .rdata_ff(mem_rdata)
  );

  // ==========================================================
  // Interrupt status: hardware set wins over a write-one clear
  wire [3:0] irq_ev = {cmp_hit & running, overrun, stop_hit, start_hit};
  wire [3:0] irq_clr = (wr_x & hit_irq) ? pwdata[3:0] : 4'h0;
  wire [3:0] nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;
  wire [3:0] nxt_mask = (wr_x & hit_mask) ? pwdata[3:0] : irq_mask_ff; // No lag on mask edits

  // ==========================================================
  // Status output sources: sampling clock, running, not empty, done
  function automatic logic stat_pick(input logic [1:0] sel, input logic sclk,
    input logic run, input logic ne, input logic fin);
    stat_pick = (sel == 2'd0) ? sclk : (sel == 2'd1) ? run : (sel == 2'd2) ? ne : fin;
  endfunction : stat_pick
  wire [1:0] nxt_stat = {stat_pick(ctrl_ff[B_ST1 +: 2], tick, running, ~empty,
    state_ff == ST_DONE), stat_pick(ctrl_ff[B_ST0 +: 2], tick, running, ~empty,
    state_ff == ST_DONE)};

  // ==========================================================
  // Read data mux; data register pops at the completing edge
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_ff) : hit_stat ? {28'(cnt_ff), full, empty,
    state_ff} : hit_irq ? {28'h0, irq_st_ff} : hit_mask ? {28'h0, irq_mask_ff}
    : hit_div ? {16'h0, div_ff} : hit_chn ? {27'h0, chn_ff} : hit_cmpv ? {16'h0, cmpv_ff}
    : hit_save ? save_ff : hit_data ? {16'h0, mem_rdata} : 32'h0;

  // APB slave: one wait state, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= access;
      pslverr_ff <= access & ~mapped;
      prdata_ff <= (access & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= CTRL_RST;
      irq_mask_ff <= 4'h0;
      div_ff <= DIV_RST;
      chn_ff <= CHN_RST;
      cmpv_ff <= 16'h0;
      save_ff <= SAVE_RST;
    end
    else if (wr_x)
    begin
      if (hit_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
      if (hit_mask) irq_mask_ff <= pwdata[3:0];
      if (hit_div) div_ff <= pwdata[15:0];
      if (hit_chn) chn_ff <= pwdata[4:0];
      if (hit_cmpv) cmpv_ff <= pwdata[15:0];
      if (hit_save) save_ff <= pwdata;
    end
  end

  // Acquisition state, pacing and buffer pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      ext_prev_ff <= 3'h0;
      div_cnt_ff <= 16'h0;
      conv_req_ff <= 1'b0;
      ch_sel_ff <= 5'h0;
      saved_ff <= 32'h0;
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      ext_prev_ff <= ext_now;
      div_cnt_ff <= nxt_div_cnt;
      conv_req_ff <= tick;
      if (tick) ch_sel_ff <= nxt_ch;
      else if (start_hit | rearm) ch_sel_ff <= 5'h0;
      saved_ff <= start_hit ? 32'h0 : saved_ff + 32'(do_wr);
      wp_ff <= rearm ? '0 : wp_ff + MEM_AW'(do_wr);
      rp_ff <= rearm ? '0 : rp_ff + MEM_AW'(adv_rp);
      cnt_ff <= nxt_cnt;
    end
  end

  // Interrupt, status pins and alongside-data pacing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_ff <= 4'h0;
      irq_ff <= 1'b0;
      stat_out_ff <= 2'b00;
      sync_tick_ff <= 1'b0;
      diff_mode_ff <= 1'b0;
    end
    else
    begin
      irq_st_ff <= nxt_irq_st;
      irq_ff <= |(nxt_irq_st & nxt_mask);
      stat_out_ff <= nxt_stat;
      sync_tick_ff <= tick & running;
      diff_mode_ff <= ctrl_ff[B_DIFF];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  diff_ch_limit_a: assert property (diff_mode_ff |-> ch_sel_ff < 5'(NCH_DIFF))
    else $error("channel beyond differential range");
  start_run_a: assert property (start_hit |=> state_ff == ST_RUN)
    else $error("start did not begin run");
  stop_done_a: assert property (stop_hit |=> state_ff == ST_DONE)
    else $error("stop did not end run");
  ext_clk_tick_a: assert property (running && ctrl_ff[B_EXTCLK] && !ctrl_ff[B_CPOL]
    && $rose(ext_clk) |=> conv_req_ff)
    else $error("external clock edge missed");
  fifo_hold_a: assert property (full && !ring && store && !pop && !rearm |=> full
    && $stable(wp_ff))
    else $error("fifo overwrote when full");
  stat_sclk_a: assert property (ctrl_ff[B_ST0 +: 2] == 2'd0 && $stable(ctrl_ff)
    |=> stat_out_ff[0] == $past(tick))
    else $error("status output not sampling clock");
  sync_pace_a: assert property (sync_tick_ff |-> conv_req_ff)
    else $error("alongside tick without sample");
  no_restart_a: assert property (state_ff == ST_DONE && !rearm |=> state_ff == ST_DONE)
    else $error("run restarted without rearm");
  irq_level_a: assert property (irq_ff == |(irq_st_ff & irq_mask_ff))
    else $error("interrupt level mismatch");
  apb_wait_a: assert property (setup ##1 (psel && penable) |=> pready_ff ##1 !pready_ff)
    else $error("apb answer timing wrong");
  run_cov: cover property (start_hit ##[1:50] stop_hit);
  ring_cov: cover property (drop);
  ovr_cov: cover property (overrun);
endmodule : aiac_top

// File: src/aiac_pkg.sv
// Shared constants for the analog input acquisition control block
package aiac_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_DIV = 8'h14;
  localparam logic [7:0] OFS_CHN = 8'h18;
  localparam logic [7:0] OFS_CMPV = 8'h1c;
  localparam logic [7:0] OFS_SAVE = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h24;
  // ==========================================================
  // Control field positions
  localparam int B_DIFF = 0;
  localparam int B_RING = 1;
  localparam int B_EXTCLK = 2;
  localparam int B_SPOL = 3;
  localparam int B_PPOL = 4;
  localparam int B_CPOL = 5;
  localparam int B_STEN = 6;
  localparam int B_SPEN = 10;
  localparam int B_ST0 = 15;
  localparam int B_ST1 = 17;
  localparam int CTRL_W = 19;
  // Command bits
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_REARM = 2;
  // Start source index: sw, compare, external, event
  localparam int S_SW = 0;
  localparam int S_CMP = 1;
  localparam int S_EXT = 2;
  localparam int S_EVT = 3;
  // Stop source index: save done, compare, external, event, sw
  localparam int P_SAVE = 0;
  localparam int P_CMP = 1;
  localparam int P_EXT = 2;
  localparam int P_EVT = 3;
  localparam int P_SW = 4;
  // Interrupt bits
  localparam int I_START = 0;
  localparam int I_STOP = 1;
  localparam int I_OVR = 2;
  localparam int I_CMP = 3;
  // ==========================================================
  // Sizes and reset values
  localparam int DW = 16;
  localparam int MEM_AW = 27;
  localparam int NCH_SE = 32;
  localparam int NCH_DIFF = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 19'h00040;
  localparam logic [15:0] DIV_RST = 16'h0019;
  localparam logic [4:0] CHN_RST = 5'h00;
  localparam logic [31:0] SAVE_RST = 32'h0000_0400;
  // Acquisition states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } aiac_state_type;
endpackage : aiac_pkg

// File: src/aiac_sample_mem.sv
// Sample buffer memory with registered read data
`timescale 1ns/1ps
module aiac_sample_mem #(
  parameter int AW = 27,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // ==========================================================
  // Single write port, registered read port
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end
endmodule : aiac_sample_mem

// File: bench/aiac_conv_model.sv
// Converter front end model answering conversion requests
`timescale 1ns/1ps
module aiac_conv_model #(
  parameter int LAT = 2
) (
  input wire logic pclk,
  input wire logic conv_req,
  input wire logic [4:0] ch,
  output logic conv_valid,
  output logic [15:0] conv_data
);
  // ==========================================================
  // Conversion pipeline
  int cnt = 0;
  logic [4:0] ch_q = 5'h00;
  // Channel shown in the tick cycle, before the design steps it on
  logic [4:0] ch_prev = 5'h00;
  initial conv_valid = 1'b0;
  initial conv_data = 16'h0000;
  // One sample per request; data idles inverted so stale values never pass
  always @(posedge pclk)
  begin
    conv_valid <= 1'b0;
    ch_prev <= ch;
    if (conv_valid)
      conv_data <= ~conv_data;
    if (conv_req)
    begin
      ch_q <= ch_prev;
      cnt <= LAT;
    end
    else if (cnt == 1)
    begin
      conv_valid <= 1'b1;
      conv_data <= 16'ha500 | {11'h000, ch_q};
    end
    if (!conv_req && cnt > 0)
      cnt <= cnt - 1;
  end
endmodule : aiac_conv_model

// File: bench/tb_analog_input_acquisition_control.sv
// Self-checking bench for the acquisition control block
`timescale 1ns/1ps
module tb_analog_input_acquisition_control;
  import aiac_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_ff, rd;
  logic pready_ff, pslverr_ff, irq_ff, conv_req_ff, diff_mode_ff, sync_tick_ff;
  logic ext_start = 1'b0, ext_stop = 1'b0, conv_valid, er;
  logic ext_clk = 1'b0, evt_start = 1'b0, evt_stop = 1'b0;
  logic [4:0] ch_sel_ff;
  logic [15:0] conv_data;
  logic [1:0] stat_out_ff;
  int n_errors = 0, samples_checked = 0;
  always #20 pclk = ~pclk;
  // ==========================================================
  // Design and converter model
  aiac_top #(.MEM_AW(6)) aiac_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .irq_ff(irq_ff), .ext_start(ext_start), .ext_stop(ext_stop), .ext_clk(ext_clk),
    .evt_start(evt_start), .evt_stop(evt_stop), .conv_req_ff(conv_req_ff),
    .ch_sel_ff(ch_sel_ff), .diff_mode_ff(diff_mode_ff), .conv_valid(conv_valid),
    .conv_data(conv_data), .stat_out_ff(stat_out_ff), .sync_tick_ff(sync_tick_ff));
  aiac_conv_model aiac_conv_model_inst (.pclk(pclk), .conv_req(conv_req_ff),
    .ch(ch_sel_ff), .conv_valid(conv_valid), .conv_data(conv_data));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; an idle edge first so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_state(input logic [1:0] st);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_STAT, 32'h0);
      n++;
    end
    while (rd[1:0] !== st && n < 100);
    chk({30'h0, rd[1:0]}, {30'h0, st});
  endtask : wait_state
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Reset values and unmapped access
  task automatic t_regs;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_0040);
    apb(1'b0, OFS_SAVE, 32'h0);
    chk(rd, 32'h0000_0400);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_regs
  // Software start, save-done stop, samples, interrupt, ignored restart
  task automatic t_sw_save;
    int i;
    apb(1'b1, OFS_CTRL, 32'h0000_0440);
    apb(1'b1, OFS_DIV, 32'h3);
    apb(1'b1, OFS_CHN, 32'h3);
    apb(1'b1, OFS_SAVE, 32'h4);
    apb(1'b1, OFS_MASK, 32'h2);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    wait_state(2'h2);
    chk({4'h0, rd[31:4]}, 32'h4);
    chk({31'h0, irq_ff}, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'ha500 + i);
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    apb(1'b1, OFS_IRQ, 32'hf);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    chk({31'h0, irq_ff}, 32'h0);
  endtask : t_sw_save
  // Falling-edge external start, rising-edge external stop, differential mode
  task automatic t_ext;
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h0000_1109);
    repeat (2) @(posedge pclk);
    chk({31'h0, diff_mode_ff}, 32'h1);
    @(posedge pclk) ext_start <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    @(posedge pclk) ext_start <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    @(posedge pclk) ext_stop <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
  endtask : t_ext
  // Ring paced by external clock: newest kept, status pins, alongside pacing
  task automatic t_ring;
    int i, n_sclk, n_sync;
    n_sclk = 0;
    n_sync = 0;
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_SAVE, 32'h46);
    apb(1'b1, OFS_CTRL, 32'h0002_0446);
    apb(1'b1, OFS_CMD, 32'h1);
    // Clock period of four cycles gives the converter room for each sample
    for (i = 0; i < 400; i++)
    begin
      @(posedge pclk);
      if (i % 2 == 1)
        ext_clk <= ~ext_clk;
      if (stat_out_ff[0] === 1'b1)
        n_sclk++;
      if (sync_tick_ff === 1'b1)
        n_sync++;
      if (i == 20)
        chk({31'h0, stat_out_ff[1]}, 32'h1);
    end
    wait_state(2'h2);
    chk({4'h0, rd[31:4]}, 32'h40);
    chk({31'h0, rd[3]}, 32'h1);
    chk({31'h0, stat_out_ff[1]}, 32'h0);
    chk({31'h0, n_sclk >= 70 && n_sclk <= 72}, 32'h1);
    chk({31'h0, n_sync >= 70 && n_sync <= 72}, 32'h1);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd, 32'ha502);
  endtask : t_ring
  // FIFO fills, keeps the oldest and flags overrun; software stop
  task automatic t_fifo;
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h0000_4040);
    apb(1'b1, OFS_IRQ, 32'hf);
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (300) @(posedge pclk);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h0000_040a);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd, 32'ha500);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd, 32'ha501);
  endtask : t_fifo
  // Compare start with event stop, then event start with software stop
  task automatic t_cmp_evt;
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_CMPV, 32'ha502);
    apb(1'b1, OFS_CTRL, 32'h0000_2080);
    repeat (30) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    @(posedge pclk) evt_stop <= 1'b1;
    @(posedge pclk) evt_stop <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h0000_4200);
    @(posedge pclk) evt_start <= 1'b1;
    @(posedge pclk) evt_start <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
  endtask : t_cmp_evt
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_sw_save();
    t_ext();
    t_ring();
    t_fifo();
    t_cmp_evt();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
endmodule : tb_analog_input_acquisition_control
